// *** hw/generic_clock_div_map.svh ***
// Register offsets, field positions, reset values and masks of the clock divider block.
`ifndef GENERIC_CLOCK_DIV_MAP_SVH
`define GENERIC_CLOCK_DIV_MAP_SVH

`define OFF_GEN_CTRL 12'h004
`define OFF_GEN_DIV 12'h008
`define OFF_GEN_PROT 12'h00C

`define IDX_LSB 0
`define IDX_MSB 3
`define DIV_LSB 8
`define DIV_MSB 23
`define CTRL_GENEN_BIT 16
`define CTRL_DIVIDE_MODE_SELECT_BIT 20
`define CTRL_WMASK 32'h003F_1F0F

`define NUM_GEN 8
`define DIV_MASK_G1 16'hFFFF
`define DIV_MASK_G2 16'h001F
`define DIV_MASK_STD 16'h00FF

`define CTRL_RST_G0 32'h0001_0600
`define CTRL_RST_G2 32'h0001_0302
`define DIV_RST 16'h0000

`endif

// *** hw/generic_clock_div_pkg.sv ***
// Types shared by the clock divider configuration block.
package generic_clock_div_pkg;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [7:0][31:0] ctrl;
    logic [7:0][15:0] div;
    logic [3:0] div_idx;
    logic [3:0] ctrl_idx;
    logic [7:0] prot_rtc;
    logic [7:0] prot_lock;
    logic [31:0] rdata;
  } cfg_state_t;

  typedef struct packed {
    logic [31:0] cnt;
    logic tick;
  } div_state_t;

  typedef enum logic [1:0] {
    REG_NONE,
    REG_CTRL,
    REG_DIV,
    REG_PROT
  } reg_sel_t;

endpackage : generic_clock_div_pkg

// *** hw/gen_clock_divider.sv ***
// One clock generator divider stage working on source ticks.
`timescale 1ns/100ps
`include "generic_clock_div_map.svh"

module gen_clock_divider (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic divide_mode_select,
  input wire logic [15:0] factor,
  input wire logic src_tick,
  output logic gen_tick
);
  import generic_clock_div_pkg::*;

  div_state_t state_r;
  div_state_t state_nxt;
  logic [31:0] term;

  // Terminal count is one less than the number of source ticks per output tick.
  function automatic logic [31:0] terminal(input logic [15:0] f, input logic dsel);
    logic [31:0] t;
    t = 32'h0000_0000;
    if (dsel) begin
      if (f >= 16'h001F) begin
        t = 32'hFFFF_FFFF;
      end else begin
        t = (32'h0000_0001 << (f[4:0] + 5'h01)) - 32'h0000_0001;
      end
    end else if (f > 16'h0001) begin
      t = {16'h0000, f} - 32'h0000_0001;
    end
    return t;
  endfunction : terminal

  assign term = terminal(factor, divide_mode_select); // [RULE_10]

  always_comb begin
    state_nxt = state_r;
    state_nxt.tick = 1'b0;
    if (!enable) begin
      state_nxt.cnt = 32'h0000_0000;
    end else if (src_tick) begin
      if (state_r.cnt >= term) begin
        state_nxt.cnt = 32'h0000_0000;
        state_nxt.tick = 1'b1;
      end else begin
        state_nxt.cnt = state_r.cnt + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign gen_tick = state_r.tick;

  a_bypass_tick: assert property (@(posedge sys_clk) disable iff (rst) // [RULE_10]
    (enable && !divide_mode_select && factor <= 16'h0001 && src_tick) |=> gen_tick)
    else $error("Undivided generator missed a tick.");
  a_div_two_pow: assert property (@(posedge sys_clk) disable iff (rst) // [RULE_10]
    (enable && divide_mode_select && factor == 16'h0000 && src_tick && state_r.cnt == 32'h0)
    |=> !gen_tick)
    else $error("Divide by two ticked on the first source tick.");

endmodule : gen_clock_divider

// *** hw/generic_clock_div_config.sv ***
// Generator division and control registers with power and user reset handling.
`timescale 1ns/100ps
`include "generic_clock_div_map.svh"

////////////////////////////////////////////////////////////////////////////////
// What this block does
// [RULE_01] The division register holds a 16-bit factor in bits 23:8 and a generator index in 3:0.
// [RULE_02] Generator 0 has 8 factor bits, generator 1 has 16, generator 2 has 5, the rest 8.
// [RULE_03] Written factor bits above a generator's width are dropped.
// [RULE_04] A written factor goes to the indexed generator 0-7; indices 8-15 do nothing.
// [RULE_05] A power reset restores every generator's division setting, protected or not.
// [RULE_06] A user reset restores a nonzero generator only when it feeds no locked or RTC clock.
// [RULE_07] After power reset the division register reads n for index n, zero factor.
// [RULE_08] After user reset generator 0 reads zero and others read n or keep when protected.
// [RULE_09] A user reset sets unprotected control 2 to 0x00010302 and 3-7 to their index.
// [RULE_10] Output is source over factor, or over two to the factor plus one with mode select.
// [RULE_11] Software wanting no division clears mode select and programs a factor of 0 or 1.
// [RULE_12] A write of the index also stores its factor field; a read returns the indexed generator's stored factor.
module generic_clock_div_config (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic user_rst,
  input generic_clock_div_pkg::apb_req_t apb_req,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] src_tick,
  output logic [7:0] gen_tick
);
  import generic_clock_div_pkg::*;

  cfg_state_t state_r;
  cfg_state_t state_nxt;
  reg_sel_t sel;
  logic wr_en;
  logic rd_setup;
  logic [7:0] prot;

  ////////////////////////////////////////////////////////////////////////////////

  // Implemented factor bits per generator.
  function automatic logic [15:0] div_mask(input int unsigned g);
    logic [15:0] m;
    m = `DIV_MASK_STD;
    if (g == 1) begin
      m = `DIV_MASK_G1;
    end else if (g == 2) begin
      m = `DIV_MASK_G2;
    end
    return m;
  endfunction : div_mask

  // Control value that a reset restores for a generator.
  function automatic logic [31:0] ctrl_reset(input int unsigned g);
    logic [31:0] v;
    v = 32'(g);
    if (g == 0) begin
      v = `CTRL_RST_G0;
    end else if (g == 2) begin
      v = `CTRL_RST_G2;
    end
    return v;
  endfunction : ctrl_reset

  function automatic reg_sel_t decode(input logic [11:0] a);
    reg_sel_t s;
    s = REG_NONE;
    if (a == `OFF_GEN_CTRL) begin
      s = REG_CTRL;
    end else if (a == `OFF_GEN_DIV) begin
      s = REG_DIV;
    end else if (a == `OFF_GEN_PROT) begin
      s = REG_PROT;
    end
    return s;
  endfunction : decode

  ////////////////////////////////////////////////////////////////////////////////

  assign sel = decode(apb_req.paddr);
  assign wr_en = apb_req.psel && apb_req.penable && apb_req.pwrite;
  assign rd_setup = apb_req.psel && !apb_req.penable;
  assign pready = apb_req.psel && apb_req.penable;
  assign pslverr = pready && (sel == REG_NONE);
  assign prdata = state_r.rdata;
  assign prot = state_r.prot_rtc | state_r.prot_lock;

  always_comb begin
    logic [3:0] id;
    id = apb_req.pwdata[`IDX_MSB:`IDX_LSB];
    state_nxt = state_r;
    if (rd_setup) begin
      state_nxt.rdata = 32'h0000_0000;
      if (sel == REG_DIV) begin
        state_nxt.rdata = {8'h00, 16'h0000, 4'h0, state_r.div_idx}; // [RULE_07]
        if (!state_r.div_idx[3]) begin
          state_nxt.rdata[`DIV_MSB:`DIV_LSB] = state_r.div[state_r.div_idx[2:0]]; // [RULE_12]
        end
      end else if (sel == REG_CTRL) begin
        state_nxt.rdata = {28'h000_0000, state_r.ctrl_idx};
        if (!state_r.ctrl_idx[3]) begin
          state_nxt.rdata = {state_r.ctrl[state_r.ctrl_idx[2:0]][31:4], state_r.ctrl_idx};
        end
      end else if (sel == REG_PROT) begin
        state_nxt.rdata = {16'h0000, state_r.prot_lock, state_r.prot_rtc};
      end
    end
    if (wr_en) begin
      if (sel == REG_DIV) begin
        state_nxt.div_idx = id; // [RULE_01]
        for (int g = 0; g < `NUM_GEN; g++) begin
          if (id == 4'(g)) begin
            // [RULE_03]
            state_nxt.div[g] = apb_req.pwdata[`DIV_MSB:`DIV_LSB] & div_mask(g); // [RULE_02] [RULE_04]
          end
        end
      end else if (sel == REG_CTRL) begin
        state_nxt.ctrl_idx = id;
        if (!id[3]) begin
          state_nxt.ctrl[id[2:0]] = (apb_req.pwdata & `CTRL_WMASK) | {28'h000_0000, id};
        end
      end else if (sel == REG_PROT) begin
        state_nxt.prot_rtc = apb_req.pwdata[7:0];
        state_nxt.prot_lock = apb_req.pwdata[15:8];
      end
    end
    // A user reset beats a write in the same cycle except to a protected generator 1-7; the protection map survives it.
    if (user_rst) begin
      state_nxt.div_idx = 4'h0;
      state_nxt.ctrl_idx = 4'h0;
      state_nxt.div[0] = `DIV_RST; // [RULE_08]
      state_nxt.ctrl[0] = `CTRL_RST_G0;
      for (int g = 1; g < `NUM_GEN; g++) begin
        if (!prot[g]) begin
          state_nxt.div[g] = `DIV_RST; // [RULE_06] [RULE_08]
          state_nxt.ctrl[g] = ctrl_reset(g); // [RULE_09]
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_r <= '0; // [RULE_05]
      for (int g = 0; g < `NUM_GEN; g++) begin
        state_r.ctrl[g] <= ctrl_reset(g);
      end
    end else begin
      state_r <= state_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////

  for (genvar g = 0; g < `NUM_GEN; g++) begin : gen_div
    gen_clock_divider u_div (
      .sys_clk(sys_clk),
      .rst(rst),
      .enable(state_r.ctrl[g][`CTRL_GENEN_BIT]),
      .divide_mode_select(state_r.ctrl[g][`CTRL_DIVIDE_MODE_SELECT_BIT]), // [RULE_10]
      .factor(state_r.div[g]),
      .src_tick(src_tick[g]),
      .gen_tick(gen_tick[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_power_reset: assert property (disable iff (1'b0) rst |=> // [RULE_05]
    (state_r.div == '0) && (state_r.ctrl[2] == `CTRL_RST_G2) && (state_r.ctrl[7] == 32'h7))
    else $error("Power reset left a division or control value.");
  a_div_store: assert property ((wr_en && sel == REG_DIV && apb_req.pwdata[3:0] == 4'h1 // [RULE_04]
    && !user_rst) |=> state_r.div[1] == $past(apb_req.pwdata[23:8]))
    else $error("Generator 1 factor not stored in full.");
  a_div_trunc: assert property ((wr_en && sel == REG_DIV && apb_req.pwdata[3:0] == 4'h2 // [RULE_03]
    && !user_rst) |=> state_r.div[2] == {11'h000, $past(apb_req.pwdata[12:8])})
    else $error("Generator 2 kept bits above its width.");
  a_div_reserved: assert property ((wr_en && sel == REG_DIV && apb_req.pwdata[3] // [RULE_04]
    && !user_rst) |=> $stable(state_r.div))
    else $error("Reserved index changed a factor.");
  a_user_keep: assert property ((user_rst && state_r.prot_rtc[3]) // [RULE_06]
    |=> state_r.div[3] == $past(state_r.div[3]) && $stable(state_r.ctrl[3]))
    else $error("Protected generator 3 lost its setting.");
  a_user_clear: assert property ((user_rst && !prot[4]) // [RULE_08]
    |=> state_r.div[4] == 16'h0 && state_r.ctrl[4] == 32'h0000_0004 && state_r.div[0] == 16'h0)
    else $error("User reset did not restore generator 4.");
  a_user_ctrl2: assert property ((user_rst && !prot[2]) |=> state_r.ctrl[2] == `CTRL_RST_G2) // [RULE_09]
    else $error("User reset did not restore control 2.");
  a_read_back: assert property ((rd_setup && sel == REG_DIV && !state_r.div_idx[3] // [RULE_12]
    && !user_rst) ##1 pready |-> prdata == {8'h00, state_r.div[state_r.div_idx[2:0]],
    4'h0, state_r.div_idx})
    else $error("Division read does not show the indexed factor.");

  c_user_prot: cover property (user_rst && prot != 8'h00);
  c_div_write: cover property (wr_en && sel == REG_DIV && apb_req.pwdata[3:0] == 4'h1);
  c_ctrl_read: cover property (rd_setup && sel == REG_CTRL ##1 pready);
  c_gen_tick: cover property (gen_tick[1]);

endmodule : generic_clock_div_config

// *** tb/testbench.sv ***
// Self-checking bench for the generator division and control registers.
`timescale 1ns/100ps
`include "generic_clock_div_map.svh"

module testbench;
  import generic_clock_div_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic user_rst = 1'b0;
  apb_req_t req = '0;
  logic [7:0] src_tick = 8'h00;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] gen_tick;
  logic [7:0] cnt [8];
  int fail_count = 0;
  int checks = 0;

  generic_clock_div_config generic_clock_div_config_i (
    .sys_clk(sys_clk),
    .rst(rst),
    .user_rst(user_rst),
    .apb_req(req),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .src_tick(src_tick),
    .gen_tick(gen_tick)
  );

  always #20 sys_clk = ~sys_clk;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic results;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : results

  // One APB transfer; the request stands until pready is seen high at a rising edge.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge sys_clk);
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= wr;
    req.paddr <= a;
    req.pwdata <= wd;
    @(posedge sys_clk);
    req.penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    if (n >= 50) begin
      fail_count++;
    end
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic err;
    apb(1'b1, a, d, rd, err);
  endtask : wr

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
    logic [31:0] rd;
    logic err;
    apb(1'b0, a, 32'h0000_0000, rd, err);
    check(rd, exp);
    check({31'h0, err}, {31'h0, exp_err});
  endtask : rdchk

  // Counts divided pulses over 24 cycles of continuous source ticks.
  task automatic run_ticks;
    @(posedge sys_clk);
    src_tick <= 8'hFF;
    repeat (30) @(posedge sys_clk);
    for (int i = 0; i < 8; i++) cnt[i] = 8'h00;
    repeat (24) begin
      @(posedge sys_clk);
      #1;
      for (int i = 0; i < 8; i++) if (gen_tick[i] === 1'b1) cnt[i]++;
    end
    @(posedge sys_clk);
    src_tick <= 8'h00;
  endtask : run_ticks

  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_power_reset;
    rdchk(`OFF_GEN_DIV, 32'h0000_0000, 1'b0);
    rdchk(`OFF_GEN_CTRL, `CTRL_RST_G0, 1'b0);
    for (int n = 1; n < 8; n++) begin
      wr(`OFF_GEN_DIV, 32'(n));
      rdchk(`OFF_GEN_DIV, 32'(n), 1'b0);
    end
    $display("test_power_reset done");
  endtask : test_power_reset

  task automatic test_width;
    logic [31:0] wd [5] = '{32'h0001_FF00, 32'h00FF_FF01, 32'hFF23_12F2, 32'h0012_3405,
                            32'h0000_AB09};
    logic [31:0] ex [5] = '{32'h0000_FF00, 32'h00FF_FF01, 32'h0000_1202, 32'h0000_3405,
                            32'h0000_0009};
    for (int k = 0; k < 5; k++) begin
      wr(`OFF_GEN_DIV, wd[k]);
      rdchk(`OFF_GEN_DIV, ex[k], 1'b0);
    end
    wr(12'h010, 32'hFFFF_FFFF);
    rdchk(12'h010, 32'h0000_0000, 1'b1);
    $display("test_width done");
  endtask : test_width

  task automatic test_dividers;
    logic [31:0] dv [8] = '{32'h0000_0100, 32'h0000_0301, 32'h0000_2602, 32'h0000_0403,
                            32'h0000_0204, 32'h0000_0005, 32'h0000_0106, 32'h0000_0C07};
    logic [7:0][7:0] e = {8'd2, 8'd6, 8'd24, 8'd3, 8'd6, 8'd4, 8'd8, 8'd24};
    for (int n = 0; n < 8; n++) begin
      wr(`OFF_GEN_DIV, dv[n]);
      wr(`OFF_GEN_CTRL, 32'h0001_0000 | ((n == 4 || n == 6) ? 32'h0010_0000 : 32'h0) | n);
    end
    run_ticks();
    for (int i = 0; i < 8; i++) check({24'h0, cnt[i]}, {24'h0, e[i]});
    $display("test_dividers done");
  endtask : test_dividers

  task automatic test_resets;
    logic [7:0][7:0] e = {8'd0, 8'd0, 8'd0, 8'd0, 8'd0, 8'd4, 8'd8, 8'd24};
    wr(`OFF_GEN_PROT, 32'h0000_0402);
    @(posedge sys_clk);
    user_rst <= 1'b1;
    @(posedge sys_clk);
    user_rst <= 1'b0;
    run_ticks();
    for (int i = 0; i < 8; i++) check({24'h0, cnt[i]}, {24'h0, e[i]});
    rdchk(`OFF_GEN_DIV, 32'h0000_0000, 1'b0);
    rdchk(`OFF_GEN_CTRL, `CTRL_RST_G0, 1'b0);
    rdchk(`OFF_GEN_PROT, 32'h0000_0402, 1'b0);
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    run_ticks();
    // Generators 0 and 2 come out of a power reset enabled with a zero factor.
    for (int i = 0; i < 8; i++) check({24'h0, cnt[i]}, (i == 0 || i == 2) ? 32'd24 : 32'd0);
    rdchk(`OFF_GEN_PROT, 32'h0000_0000, 1'b0);
    $display("test_resets done");
  endtask : test_resets

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    test_power_reset();
    test_width();
    test_dividers();
    test_resets();
    results();
  end

  // A hang is cut short well beyond the few hundred cycles the tests need.
  initial begin
    #(40 * 20000);
    fail_count++;
    results();
  end
endmodule : testbench
